// ===== hdl/pmch_top.sv
// Notes on behaviour
// - Header is a read-only dword at offset 0x50; writes change nothing.
// - Bits 7:0 read 01h, the power-management capability identifier.
// - Bits 18:16 read 3'b011, interface version 1.2.
// - Bit 30 reads 1, wake event possible from D3 hot.
// - Bits 29, 28, 27 read 0, no wake from D2, D1, D0.
// - Bits 26 and 25 read 1, D2 and D1 states supported.
// - Bits 24:22 read 000, required while D3 cold wake is unsupported.
// - Bit 21 reads 0, no special initialisation after uninitialised D0.
// - Bit 20 is reserved and reads 0.
// - Bit 19 reads 1 when wake signalling needs the bus clock running.
// - Bit 31 reads 0, no D3 cold wake, matching zero auxiliary current.
// - Capabilities pointer at offset 0x34 reads 50h to reach this header.
`timescale 1ns/10ps
`default_nettype none

module pmch_top
#(
    parameter logic PME_CLOCK_DEP = 1'b1,
    parameter logic PME_D3COLD    = 1'b0
)
(
    // Clock, reset, enable
    input  wire logic                                CORE_CLK_IN,
    input  wire logic                                RESETN_IN,
    input  wire logic                                CLK_EN_IN,

    // Configuration access request
    input  wire logic                                CFG_RD_IN,
    input  wire logic                                CFG_WR_IN,
    input  wire logic [pmch_pkg::CFG_ADDR_W-1:0]     CFG_ADDR_IN,
    input  wire logic [pmch_pkg::CFG_BE_W-1:0]       CFG_BE_IN,
    input  wire logic [pmch_pkg::CFG_DATA_W-1:0]     CFG_WDATA_IN,

    // Configuration access answer
    output var  logic                                CFG_DONE_OUT,
    output var  logic                                CFG_HIT_OUT,
    output var  logic                                CFG_WR_DROP_OUT,
    output var  logic [pmch_pkg::CFG_DATA_W-1:0]     CFG_RDATA_OUT
);

    ////////////////////////////////////////////////////////////////////////////
    // Elaboration checks
    // Refuse settings that the constant word or the decode cannot serve

    generate
        if (PME_D3COLD != 1'b0)
        begin : g_bad_d3cold
            $error("D3 cold wake needs a nonzero auxiliary current field");
        end
        if (pmch_pkg::CFG_DATA_W != 32)
        begin : g_bad_width
            $error("Configuration data path must be 32 bits");
        end
        if (pmch_pkg::CFG_ADDR_W != $bits(pmch_pkg::OFS_PM_HDR))
        begin : g_bad_addr
            $error("Configuration offsets need an address as wide as the offset constants");
        end
        if (pmch_pkg::CFG_BE_W * $bits(byte) != pmch_pkg::CFG_DATA_W)
        begin : g_bad_be
            $error("One byte enable per data byte is required");
        end
        if ((pmch_pkg::OFS_PM_HDR[1:0] != pmch_pkg::DWORD_LSB_ZERO) ||
            (pmch_pkg::OFS_CAP_PTR[1:0] != pmch_pkg::DWORD_LSB_ZERO))
        begin : g_bad_align
            $error("Register offsets must be dword aligned");
        end
        if (pmch_pkg::CAP_PTR_WORD[pmch_pkg::CFG_ADDR_W-1:0] != pmch_pkg::OFS_PM_HDR)
        begin : g_bad_ptr
            $error("Capabilities pointer must lead to the header");
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////
    // Constant header word

    logic [31:0] hdr_word;

    pmch_hdr_word
    #(
        .PME_CLOCK_DEP (PME_CLOCK_DEP),
        .PME_D3COLD    (PME_D3COLD)
    )
    u_hdr_word
    (
        .hdr_word_out  (hdr_word)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Address decode

    logic        aligned;
    logic        sel_hdr;
    logic        sel_ptr;
    logic        req;
    logic        req_rd;
    logic        req_wr;
    logic [31:0] rd_word;

    always_comb
    begin
        aligned = (CFG_ADDR_IN[1:0] == pmch_pkg::DWORD_LSB_ZERO);
        sel_hdr = aligned && (CFG_ADDR_IN == pmch_pkg::OFS_PM_HDR);
        sel_ptr = aligned && (CFG_ADDR_IN == pmch_pkg::OFS_CAP_PTR);
        req     = CFG_RD_IN || CFG_WR_IN;
        req_rd  = CFG_RD_IN;
        // Both strobes together are served as a read
        req_wr  = CFG_WR_IN && !CFG_RD_IN;
        // Unknown offsets read as zero but still complete
        if (sel_hdr)
        begin
            rd_word = hdr_word;
        end
        else if (sel_ptr)
        begin
            rd_word = pmch_pkg::CAP_PTR_WORD;
        end
        else
        begin
            rd_word = pmch_pkg::WORD_ZERO;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Access sequencer
    // A request is taken in idle; done then stands for one enabled cycle,
    // and a request still held during that cycle is not taken twice.

    pmch_pkg::pmch_state_t state_r;
    pmch_pkg::pmch_state_t state_nxt;
    logic                  done_r;
    logic                  done_nxt;
    logic                  hit_r;
    logic                  hit_nxt;
    logic                  drop_r;
    logic                  drop_nxt;
    logic [31:0]           rdata_r;
    logic [31:0]           rdata_nxt;

    always_comb
    begin
        state_nxt = state_r;
        done_nxt  = 1'b0;
        hit_nxt   = 1'b0;
        drop_nxt  = 1'b0;
        rdata_nxt = pmch_pkg::WORD_ZERO;
        case (state_r)
            pmch_pkg::ST_IDLE:
            begin
                if (req)
                begin
                    state_nxt = pmch_pkg::ST_DONE;
                    done_nxt  = 1'b1;
                    hit_nxt   = sel_hdr || sel_ptr;
                    if (req_rd)
                    begin
                        rdata_nxt = rd_word;
                    end
                    if (req_wr)
                    begin
                        drop_nxt = 1'b1;
                    end
                end
            end
            pmch_pkg::ST_DONE:
            begin
                // A request still held here is not taken again
                state_nxt = pmch_pkg::ST_IDLE;
            end
            default:
            begin
                // Unused code falls back to idle
                state_nxt = pmch_pkg::ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge CORE_CLK_IN)
    begin
        // Reset takes effect even while the clock enable is low
        if (!RESETN_IN)
        begin
            state_r <= pmch_pkg::ST_IDLE;
            done_r  <= 1'b0;
            hit_r   <= 1'b0;
            drop_r  <= 1'b0;
            rdata_r <= pmch_pkg::WORD_ZERO;
        end
        else if (CLK_EN_IN)
        begin
            state_r <= state_nxt;
            done_r  <= done_nxt;
            hit_r   <= hit_nxt;
            drop_r  <= drop_nxt;
            rdata_r <= rdata_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Outputs

    // Write data and byte enables are accepted but never stored
    logic unused_ok;

    always_comb
    begin
        unused_ok = ^{CFG_WDATA_IN, CFG_BE_IN};
    end

    always_comb
    begin
        CFG_DONE_OUT    = done_r;
        CFG_HIT_OUT     = hit_r;
        CFG_WR_DROP_OUT = drop_r;
        CFG_RDATA_OUT   = rdata_r;
    end

endmodule

`default_nettype wire

// ===== hdl/pmch_pkg.sv
`default_nettype none

package pmch_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // Configuration access geometry
    localparam int          CFG_ADDR_W      = 8;
    localparam int          CFG_DATA_W      = 32;
    localparam int          CFG_BE_W        = 4;

    // Dword offsets in configuration space
    localparam logic [7:0]  OFS_CAP_PTR     = 8'h34;
    localparam logic [7:0]  OFS_PM_HDR      = 8'h50;
    localparam logic [1:0]  DWORD_LSB_ZERO  = 2'h0;

    ////////////////////////////////////////////////////////////////////////////
    // Power-management capability header field positions
    localparam int          CAP_ID_LSB      = 0;
    localparam int          NEXT_PTR_LSB    = 8;
    localparam int          PM_VER_LSB      = 16;
    localparam int          PME_CLK_BIT     = 19;
    localparam int          RSVD_BIT        = 20;
    localparam int          DSI_BIT         = 21;
    localparam int          AUX_CUR_LSB     = 22;
    localparam int          D1_SUP_BIT      = 25;
    localparam int          D2_SUP_BIT      = 26;
    localparam int          PME_D0_BIT      = 27;
    localparam int          PME_D1_BIT      = 28;
    localparam int          PME_D2_BIT      = 29;
    localparam int          PME_D3HOT_BIT   = 30;
    localparam int          PME_D3COLD_BIT  = 31;

    // Field values
    localparam logic [7:0]  CAP_ID_PM       = 8'h01;
    localparam logic [7:0]  NEXT_PTR_LAST   = 8'h00;
    localparam logic [2:0]  PM_VER_1_2      = 3'h3;
    localparam logic [2:0]  AUX_CUR_NONE    = 3'h0;
    localparam logic        BIT_SET         = 1'b1;
    localparam logic        BIT_CLR         = 1'b0;

    // Capabilities pointer word: low byte points at the header, rest reserved
    localparam logic [31:0] CAP_PTR_WORD    = 32'h0000_0050;
    localparam logic [31:0] WORD_ZERO       = 32'h0000_0000;

    ////////////////////////////////////////////////////////////////////////////
    // Access sequencer states
    typedef enum logic [0:0]
    {
        ST_IDLE = 1'b0,
        ST_DONE = 1'b1
    } pmch_state_t;

endpackage

`default_nettype wire

// ===== hdl/pmch_hdr_word.sv
`timescale 1ns/10ps
`default_nettype none

module pmch_hdr_word
#(
    parameter logic PME_CLOCK_DEP = 1'b1,
    parameter logic PME_D3COLD    = 1'b0
)
(
    // Assembled header word
    output var logic [31:0] hdr_word_out
);

    always_comb
    begin
        hdr_word_out = pmch_pkg::WORD_ZERO;
        hdr_word_out[pmch_pkg::CAP_ID_LSB +: 8]   = pmch_pkg::CAP_ID_PM;
        hdr_word_out[pmch_pkg::NEXT_PTR_LSB +: 8] = pmch_pkg::NEXT_PTR_LAST;
        hdr_word_out[pmch_pkg::PM_VER_LSB +: 3]   = pmch_pkg::PM_VER_1_2;
        hdr_word_out[pmch_pkg::PME_CLK_BIT]       = PME_CLOCK_DEP;
        hdr_word_out[pmch_pkg::RSVD_BIT]          = pmch_pkg::BIT_CLR;
        hdr_word_out[pmch_pkg::DSI_BIT]           = pmch_pkg::BIT_CLR;
        hdr_word_out[pmch_pkg::AUX_CUR_LSB +: 3]  = pmch_pkg::AUX_CUR_NONE;
        hdr_word_out[pmch_pkg::D1_SUP_BIT]        = pmch_pkg::BIT_SET;
        hdr_word_out[pmch_pkg::D2_SUP_BIT]        = pmch_pkg::BIT_SET;
        hdr_word_out[pmch_pkg::PME_D0_BIT]        = pmch_pkg::BIT_CLR;
        hdr_word_out[pmch_pkg::PME_D1_BIT]        = pmch_pkg::BIT_CLR;
        hdr_word_out[pmch_pkg::PME_D2_BIT]        = pmch_pkg::BIT_CLR;
        hdr_word_out[pmch_pkg::PME_D3HOT_BIT]     = pmch_pkg::BIT_SET;
        hdr_word_out[pmch_pkg::PME_D3COLD_BIT]    = PME_D3COLD;
    end

endmodule

`default_nettype wire

// ===== tb/pmch_monitor.sv
`timescale 1ns/10ps
`default_nettype none

module pmch_monitor
#(
    parameter logic PME_CLOCK_DEP = 1'b1,
    parameter logic PME_D3COLD    = 1'b0
)
(
    // Clock and reset
    input wire logic        CORE_CLK_IN,
    input wire logic        RESETN_IN,
    // Access observed
    input wire logic        CFG_RD_IN,
    input wire logic [7:0]  CFG_ADDR_IN,
    input wire logic        CFG_DONE_OUT,
    input wire logic [31:0] CFG_RDATA_OUT
);
    default clocking @(posedge CORE_CLK_IN); endclocking
    default disable iff (!RESETN_IN);

    sequence hdr_rd;
        CFG_DONE_OUT && CFG_RD_IN && CFG_ADDR_IN == 8'h50;
    endsequence
    sequence ptr_rd;
        CFG_DONE_OUT && CFG_RD_IN && CFG_ADDR_IN == 8'h34;
    endsequence

    a_cap_id: assert property (hdr_rd |-> CFG_RDATA_OUT[7:0] == 8'h01)
        else $error("capability id wrong");
    a_next_link: assert property (hdr_rd |-> CFG_RDATA_OUT[15:8] == 8'h00)
        else $error("next link wrong");
    a_pm_version: assert property (hdr_rd |-> CFG_RDATA_OUT[18:16] == 3'h3)
        else $error("version wrong");
    a_d3hot_wake: assert property (hdr_rd |-> CFG_RDATA_OUT[30])
        else $error("d3 hot wake bit wrong");
    a_low_wake: assert property (hdr_rd |-> CFG_RDATA_OUT[29:27] == 3'h0)
        else $error("low state wake bits wrong");
    a_dstate_support: assert property (hdr_rd |-> CFG_RDATA_OUT[26:25] == 2'h3)
        else $error("state support bits wrong");
    a_aux_current: assert property (hdr_rd |-> CFG_RDATA_OUT[24:22] == 3'h0)
        else $error("aux current wrong");
    a_init_rsvd: assert property (hdr_rd |-> CFG_RDATA_OUT[21:20] == 2'h0)
        else $error("init or reserved bit wrong");
    a_clock_dep: assert property (hdr_rd |-> CFG_RDATA_OUT[19] == PME_CLOCK_DEP)
        else $error("clock dependence wrong");
    a_d3cold_wake: assert property (hdr_rd |-> CFG_RDATA_OUT[31] == PME_D3COLD)
        else $error("d3 cold wake bit wrong");
    a_cap_pointer: assert property (ptr_rd |-> CFG_RDATA_OUT == 32'h0000_0050)
        else $error("capability pointer wrong");
endmodule

bind pmch_top pmch_monitor #(.PME_CLOCK_DEP(PME_CLOCK_DEP), .PME_D3COLD(PME_D3COLD)) pmch_monitor_i
    (.CORE_CLK_IN(CORE_CLK_IN), .RESETN_IN(RESETN_IN), .CFG_RD_IN(CFG_RD_IN), .CFG_ADDR_IN(CFG_ADDR_IN),
     .CFG_DONE_OUT(CFG_DONE_OUT), .CFG_RDATA_OUT(CFG_RDATA_OUT));

`default_nettype wire

// ===== tb/pmch_cfg_master.sv
`timescale 1ns/10ps
`default_nettype none

module pmch_cfg_master
(
    // Clock
    input  wire logic        clk_in,
    // Request
    output var  logic        rd_out,
    output var  logic        wr_out,
    output var  logic [7:0]  addr_out,
    output var  logic [3:0]  be_out,
    output var  logic [31:0] wdata_out,
    // Answer
    input  wire logic        done_in,
    input  wire logic        hit_in,
    input  wire logic        drop_in,
    input  wire logic [31:0] rdata_in
);
    initial
    begin
        {rd_out, wr_out, addr_out, be_out, wdata_out} = '0;
    end

    // Request held until done is sampled or 16 cycles pass, then bus shows inverted leftovers
    task automatic xfer(input logic rd, input logic [7:0] a, input logic [3:0] be, input logic [31:0] wd,
                        output logic [31:0] rdat, output logic hit, output logic drop, output logic ok);
        ok = 1'b0;
        @(posedge clk_in);
        #1;
        {rd_out, wr_out, addr_out, be_out, wdata_out} = {rd, !rd, a, be, wd};
        for (int i = 0; i < 16 && !ok; i++)
        begin
            @(posedge clk_in);
            if (done_in === 1'b1)
            begin
                {ok, rdat, hit, drop} = {1'b1, rdata_in, hit_in, drop_in};
            end
        end
        #1;
        {rd_out, wr_out, addr_out, be_out, wdata_out} = {2'b00, ~a, ~be, ~wd};
    endtask
endmodule

`default_nettype wire

// ===== tb/tb.sv
`timescale 1ns/10ps
`default_nettype none

module tb;
    logic        clk = 1'b0;
    logic        rst_n = 1'b0;
    logic        en = 1'b1;
    logic        rd, wr, done, hit, drop, ok, h, dr;
    logic [7:0]  addr, a;
    logic [3:0]  be;
    logic [31:0] wdata, rdata, d;
    logic [15:0] lf = 16'h12BB;
    int          n_mismatch = 0;
    int          cmp_count = 0;

    initial
    begin
        forever #2 clk = ~clk;
    end

    pmch_top pmch_top_i (.CORE_CLK_IN(clk), .RESETN_IN(rst_n), .CLK_EN_IN(en), .CFG_RD_IN(rd),
        .CFG_WR_IN(wr), .CFG_ADDR_IN(addr), .CFG_BE_IN(be), .CFG_WDATA_IN(wdata), .CFG_DONE_OUT(done),
        .CFG_HIT_OUT(hit), .CFG_WR_DROP_OUT(drop), .CFG_RDATA_OUT(rdata));
    pmch_cfg_master pmch_cfg_master_i (.clk_in(clk), .rd_out(rd), .wr_out(wr), .addr_out(addr), .be_out(be),
        .wdata_out(wdata), .done_in(done), .hit_in(hit), .drop_in(drop), .rdata_in(rdata));

    function automatic logic [15:0] lfsr(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction

    function automatic logic [31:0] hdr_exp();
        return {1'b0, 1'b1, 3'h0, 2'h3, 3'h0, 2'h0, 1'b1, 3'h3, 8'h00, 8'h01};
    endfunction

    function automatic logic [31:0] rd_exp(input logic [7:0] ofs);
        if (ofs == 8'h50)
            return hdr_exp();
        if (ofs == 8'h34)
            return 32'h0000_0050;
        return 32'h0000_0000;
    endfunction

    task automatic chk(input logic [35:0] got, input logic [35:0] exp);
        cmp_count++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic stop_test();
        $display("compares=%0d mismatches=%0d", cmp_count, n_mismatch);
        if (n_mismatch == 0 && cmp_count > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    task automatic rd_hdr();
        pmch_cfg_master_i.xfer(1'b1, 8'h50, 4'hF, 32'h0000_0000, d, h, dr, ok);
        chk({ok, h, dr, d}, {3'b110, hdr_exp()});
    endtask

    task automatic do_reset();
        #1 rst_n = 1'b0;
        repeat (8) @(posedge clk);
        #1 rst_n = 1'b1;
    endtask

    initial
    begin
        do_reset();
        rd_hdr();
        pmch_cfg_master_i.xfer(1'b1, 8'h34, 4'hF, 32'h0000_0000, d, h, dr, ok);
        chk({ok, h, dr, d}, {3'b110, 32'h0000_0050});
        en = 1'b0;
        fork
            rd_hdr();
            begin
                repeat (5)
                begin
                    @(posedge clk);
                    #1;
                    chk({35'h0, done}, 36'h0);
                end
                en = 1'b1;
            end
        join
        for (int i = 0; i < 40; i++)
        begin
            lf = lfsr(lf);
            a = (i % 4 == 0) ? 8'h50 : {lf[7:2], 2'h0};
            pmch_cfg_master_i.xfer(1'b0, a, lf[3:0], {lf, ~lf}, d, h, dr, ok);
            chk({ok, h, dr}, {1'b1, a == 8'h50 || a == 8'h34, 1'b1});
            rd_hdr();
            pmch_cfg_master_i.xfer(1'b1, a, 4'hF, 32'h0000_0000, d, h, dr, ok);
            chk({ok, h, dr, d}, {1'b1, a == 8'h50 || a == 8'h34, 1'b0, rd_exp(a)});
        end
        do_reset();
        rd_hdr();
        stop_test();
    end

    initial
    begin
        #100000;
        n_mismatch++;
        stop_test();
    end
endmodule

`default_nettype wire
